// file: rtl/bdm_map.svh
// Purpose: Address map, field positions and reset values of the data memory block
// Assumes: Largest variant: fifteen general banks plus the display bank
// Notes:   Definitions only
`ifndef BDM_MAP_SVH
`define BDM_MAP_SVH
// Special register locations in bank zero
`define BDM_IND_A_ADDR   8'h00
`define BDM_PTR_A_ADDR   8'h01
`define BDM_IND_B_ADDR   8'h02
`define BDM_PTR_B_ADDR   8'h03
`define BDM_BANK_ADDR    8'h04
`define BDM_ACC_ADDR     8'h05
`define BDM_STATUS_ADDR  8'h0a
// Embedded control window, tone control first
`define BDM_PERIPH_LO    8'h20
`define BDM_PERIPH_HI    8'h37
`define BDM_PERIPH_MASK  24'hf0ef57
`define BDM_PERIPH_WORDS 24
// Banked general memory
`define BDM_GPR_LO       8'h40
`define BDM_LCD_HI       8'h9f
`define BDM_LAST_BANK    6'h0e
`define BDM_LCD_BANK     6'h1b
`define BDM_BANK_SPAN    12'h0c0
`define BDM_GPR_WORDS    2880
`define BDM_LCD_WORDS    96
// Status flag positions
`define BDM_FLAG_C       0
`define BDM_FLAG_AC      1
`define BDM_FLAG_Z       2
`define BDM_FLAG_OV      3
// Reset values
`define BDM_RST_BYTE     8'h00
`define BDM_RST_BANK     6'h00
`define BDM_RST_FLAGS    4'h0
`endif

// file: rtl/bdm_pkg.sv
// Purpose: Types shared by the data memory block and its arithmetic unit
// Assumes: Operation codes are issued by the core decode logic
// Notes:   Constants live in bdm_map.svh
package bdm_pkg;
  // Operations the core may issue, one per cycle
  typedef enum logic [4:0] {
    BDM_NOP = 5'h00, BDM_LD  = 5'h01, BDM_ST  = 5'h02, BDM_ADD = 5'h03,
    BDM_ADC = 5'h04, BDM_SUB = 5'h05, BDM_SBC = 5'h06, BDM_DAA = 5'h07,
    BDM_AND = 5'h08, BDM_OR  = 5'h09, BDM_XOR = 5'h0a, BDM_CPL = 5'h0b,
    BDM_RL  = 5'h0c, BDM_RR  = 5'h0d, BDM_RLC = 5'h0e, BDM_RRC = 5'h0f,
    BDM_INC = 5'h10, BDM_DEC = 5'h11, BDM_SZ  = 5'h12, BDM_SNZ = 5'h13,
    BDM_SIZ = 5'h14, BDM_SDZ = 5'h15
  } bdm_op_t;
  // Where a resolved address lands
  typedef enum logic [1:0] {
    BDM_TGT_NONE = 2'b00, BDM_TGT_SFR = 2'b01, BDM_TGT_GPR = 2'b10, BDM_TGT_LCD = 2'b11
  } bdm_tgt_t;
endpackage : bdm_pkg

// file: rtl/bdm_alu.sv
// Purpose: Eight-bit arithmetic, logic, rotate and skip decision unit
// Assumes: Purely combinational; the caller registers everything
// Notes:   upd marks which status flags this operation owns
`include "bdm_map.svh"
`timescale 1ns/100ps
`default_nettype none
module bdm_alu (
  input  wire bdm_pkg::bdm_op_t op,
  input  wire logic [7:0]       acc,
  input  wire logic [7:0]       src,
  input  wire logic [3:0]       flags_in,
  output logic      [7:0]       res,
  output logic      [3:0]       flg,
  output logic      [3:0]       upd,
  output logic                  skip
);
  logic [8:0] w;    // Full adder output with carry
  logic [4:0] h;    // Low nibble sum for half carry
  logic [7:0] b;    // Second adder operand, inverted for subtract
  logic       cin;  // Adder carry in
  logic       hadj; // High nibble decimal fix needed

  // One shared adder serves add and subtract forms
  always_comb begin
    w    = 9'h000;
    h    = 5'h00;
    b    = src;
    cin  = 1'b0;
    hadj = 1'b0;
    res  = src;
    flg  = flags_in;
    upd  = 4'h0;
    skip = 1'b0;
    case (op)
      bdm_pkg::BDM_ADD, bdm_pkg::BDM_ADC,
      bdm_pkg::BDM_SUB, bdm_pkg::BDM_SBC: begin // RQ10
        b   = (op == bdm_pkg::BDM_SUB || op == bdm_pkg::BDM_SBC) ? ~src : src;
        cin = (op == bdm_pkg::BDM_SUB) ? 1'b1 :
              (op == bdm_pkg::BDM_ADD) ? 1'b0 : flags_in[`BDM_FLAG_C];
        w   = {1'b0, acc} + {1'b0, b} + {8'h00, cin};
        h   = {1'b0, acc[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        res = w[7:0];
        // Carry set means no borrow on subtract
        flg[`BDM_FLAG_C]  = w[8]; // RQ18
        flg[`BDM_FLAG_AC] = h[4]; // RQ18
        flg[`BDM_FLAG_OV] = (acc[7] == b[7]) && (w[7] != acc[7]); // RQ18
        upd = 4'hf; // RQ14
      end
      bdm_pkg::BDM_DAA: begin // RQ10
        w    = {1'b0, acc} + ((acc[3:0] > 4'h9 || flags_in[`BDM_FLAG_AC]) ? 9'h006 : 9'h000);
        hadj = w[8] || flags_in[`BDM_FLAG_C] || (w[7:4] > 4'h9);
        res  = w[7:0] + (hadj ? 8'h60 : 8'h00);
        flg[`BDM_FLAG_C] = hadj || (hadj && (w[7:4] > 4'h9));
        upd  = 4'h1; // RQ14
      end
      bdm_pkg::BDM_AND: begin res = acc & src; upd = 4'h4; end // RQ11
      bdm_pkg::BDM_OR:  begin res = acc | src; upd = 4'h4; end // RQ11
      bdm_pkg::BDM_XOR: begin res = acc ^ src; upd = 4'h4; end // RQ11
      bdm_pkg::BDM_CPL: begin res = ~src;      upd = 4'h4; end // RQ11
      bdm_pkg::BDM_RL:  res = {src[6:0], src[7]}; // RQ12
      bdm_pkg::BDM_RR:  res = {src[0], src[7:1]}; // RQ12
      bdm_pkg::BDM_RLC: begin // RQ12
        res = {src[6:0], flags_in[`BDM_FLAG_C]};
        flg[`BDM_FLAG_C] = src[7];
        upd = 4'h1;
      end
      bdm_pkg::BDM_RRC: begin // RQ12
        res = {flags_in[`BDM_FLAG_C], src[7:1]};
        flg[`BDM_FLAG_C] = src[0];
        upd = 4'h1;
      end
      bdm_pkg::BDM_INC: begin res = src + 8'h01; upd = 4'h4; end // RQ13
      bdm_pkg::BDM_DEC: begin res = src - 8'h01; upd = 4'h4; end // RQ13
      bdm_pkg::BDM_SZ:  skip = (src == 8'h00); // RQ13
      bdm_pkg::BDM_SNZ: skip = (src != 8'h00); // RQ13
      bdm_pkg::BDM_SIZ: begin res = src + 8'h01; skip = (res == 8'h00); end // RQ13
      bdm_pkg::BDM_SDZ: begin res = src - 8'h01; skip = (res == 8'h00); end // RQ13
      bdm_pkg::BDM_ST:  res = acc;
      default:          res = src;
    endcase
    // Zero flag follows the result wherever the operation owns it
    flg[`BDM_FLAG_Z] = (res == 8'h00); // RQ18
  end
endmodule : bdm_alu
`default_nettype wire

// file: rtl/bdm_top.sv
// Purpose: Banked data memory, pointer indirection, working register and status flags
// Assumes: Core issues one operation per cycle with op_valid; all inputs on clk
// Notes:   Every operation completes in one cycle; results appear the next cycle
// Notes on behaviour
// RQ1: General memory 40H-FFH in every bank
// RQ2: Display memory 40H-9FH of display bank
// RQ3: 00H and 02H forward through pointers
// RQ4: Pointer at 00H/02H reads zero, writes nothing
// RQ5: Pointer a bank zero; pointer b uses bank_select
// RQ6: Indirect 00H-3FH always hits bank zero
// RQ7: Pointers eight bits; bank_select six bits
// RQ8: Working register at 05H, takes immediates
// RQ9: No memory to memory path
// RQ10: Add, carry add, subtract, borrow subtract, decimal adjust
// RQ11: AND, OR, XOR, complement
// RQ12: Plain and through-carry rotates both ways
// RQ13: Increment, decrement and skip decisions
// RQ14: Operations update status flags
// RQ15: Control registers fixed at 20H-37H
// RQ16: Unassigned locations below 40H read zero
// RQ17: Banks above zero only via pointer b
// RQ18: Zero, carry, half carry, overflow flag layout
// RQ19: Direct upper area uses bank_select, resets zero; code drops a direct access when bank_select is not zero
// RQ20: Unimplemented banks read zero, ignore writes
`include "bdm_map.svh"
`timescale 1ns/100ps
`default_nettype none
module bdm_top (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             op_valid,
  input  wire bdm_pkg::bdm_op_t op_code,
  input  wire logic [7:0]       op_addr,
  input  wire logic [7:0]       op_imm,
  input  wire logic             op_use_imm,
  input  wire logic             op_to_acc,
  output logic                  op_done_r,
  output logic                  skip_r,
  output logic [7:0]            rd_data_r,
  output logic [7:0]            working_register_r,
  output logic [3:0]            flags_r,
  output logic [5:0]            bank_select_r,
  output logic [7:0]            pointer_a_r,
  output logic [7:0]            pointer_b_r,
  output logic [7:0]            tone_gen_control_r
);
  // Storage arrays; general and display memory have no reset, so their contents are undefined at power up
  logic [7:0] gpr_r    [0:`BDM_GPR_WORDS-1];    // Fifteen banks of 192 bytes
  logic [7:0] lcd_r    [0:`BDM_LCD_WORDS-1];    // Display memory
  logic [7:0] periph_r [0:`BDM_PERIPH_WORDS-1]; // Control registers, held here

  // Map overview, bank zero view:
  // 00H phantom port through pointer a
  // 01H pointer a
  // 02H phantom port through pointer b
  // 03H pointer b
  // 04H bank select, six bits
  // 05H working register
  // 0AH status, low four bits only
  // 20H-37H control bytes, sparse
  // 40H-FFH general memory per bank
  // Display bank: 40H-9FH only
  // Everything else reads zero
  // Upper banks need pointer b; a
  // direct access there is dropped
  // rather than aliased to bank zero,
  // so stray code cannot corrupt the
  // shared bank zero variables
  // Resolved access
  logic [7:0]        ea;         // Effective address
  logic [5:0]        bank;       // Effective bank
  logic              ind;        // Access goes through a pointer
  bdm_pkg::bdm_tgt_t tgt;        // Target class
  logic [11:0]       gidx;       // General memory index
  logic [6:0]        lidx;       // Display memory index
  logic [4:0]        pidx;       // Control register index
  logic [7:0]        mem_rd;     // Data read from the target
  logic [7:0]        src;        // Operand into the arithmetic unit
  logic [7:0]        res;        // Arithmetic unit result
  logic [3:0]        alu_flg;    // Flags computed by the unit
  logic [3:0]        alu_upd;    // Flags the unit owns
  logic              alu_skip;   // Skip decision
  logic              wr_mem;     // Operation writes memory
  logic              wr_acc;     // Operation writes the working register

  // Next values of control state
  logic              op_done_nxt;
  logic              skip_nxt;
  logic [7:0]        rd_data_nxt;
  logic [7:0]        acc_nxt;
  logic [3:0]        flags_nxt;
  logic [5:0]        bank_nxt;
  logic [7:0]        ptr_a_nxt;
  logic [7:0]        ptr_b_nxt;

  // Next values of storage: one write port per array
  logic              gpr_we_nxt;
  logic              lcd_we_nxt;
  logic              periph_we_nxt;
  logic [7:0]        wdata;

  // Control register exists at this offset from 20H
  // A literal cannot be bit-selected, so the mask is copied into a
  // variable first and indexed there
  function automatic logic periph_ok(input logic [7:0] a);
    logic [7:0]  off;  // Offset from the window base
    logic [23:0] mask; // One bit per implemented control byte
    off  = a - `BDM_PERIPH_LO;
    mask = `BDM_PERIPH_MASK;
    periph_ok = (a >= `BDM_PERIPH_LO) && (a <= `BDM_PERIPH_HI)
                && mask[off[4:0]]; // RQ15
  endfunction : periph_ok

  // Flat index of a byte in the general banks
  function automatic logic [11:0] gpr_index(input logic [5:0] bk, input logic [7:0] a);
    logic [7:0] off;
    off = a - `BDM_GPR_LO;
    gpr_index = ({6'h00, bk} * `BDM_BANK_SPAN) + {4'h0, off}; // RQ1
  endfunction : gpr_index

  // Writes land on results, not on the operand: only unit ops and stores write
  function automatic logic op_writes(input bdm_pkg::bdm_op_t op);
    op_writes = (op != bdm_pkg::BDM_NOP) && (op != bdm_pkg::BDM_SZ)
                && (op != bdm_pkg::BDM_SNZ);
  endfunction : op_writes

  // Tone control is the first control register
  assign tone_gen_control_r = periph_r[0]; // RQ15

  // Address resolution and read mux
  // Resolution order matters:
  // 1. a pointer aimed at a phantom
  //    port gives nothing, which
  //    stops endless indirection
  // 2. below 40H is bank zero, for
  //    any bank select value
  // 3. bank zero general memory
  // 4. upper banks, pointer b only
  // 5. display bank, lower part
  // 6. anything else is empty
  // Only one read port per array is
  // needed since one op runs a cycle
  // Limitation: general memory is
  // not reset, so reading before a
  // write gives an undefined byte
  // The read path is long (pointer
  // to index multiply to array), the
  // price of single cycle operation
  always_comb begin
    ind  = (op_addr == `BDM_IND_A_ADDR) || (op_addr == `BDM_IND_B_ADDR); // RQ3
    // Phantom ports forward to the pointers
    if (op_addr == `BDM_IND_A_ADDR) begin
      ea   = pointer_a_r; // RQ3
      bank = `BDM_RST_BANK; // RQ5
    end else if (op_addr == `BDM_IND_B_ADDR) begin
      ea   = pointer_b_r; // RQ3
      bank = bank_select_r; // RQ5
    end else begin
      ea   = op_addr;
      bank = bank_select_r; // RQ19
    end
    gidx = gpr_index(bank, ea);
    lidx = 7'(ea - `BDM_GPR_LO);
    pidx = 5'(ea - `BDM_PERIPH_LO);
    // Classify the target
    if (ind && (ea == `BDM_IND_A_ADDR || ea == `BDM_IND_B_ADDR)) begin
      tgt = bdm_pkg::BDM_TGT_NONE; // RQ4
    end else if (ea < `BDM_GPR_LO) begin
      tgt = bdm_pkg::BDM_TGT_SFR; // RQ6
    end else if (bank == `BDM_RST_BANK) begin
      tgt = bdm_pkg::BDM_TGT_GPR; // RQ1
    end else if (op_addr != `BDM_IND_B_ADDR) begin
      // Upper banks are not reachable by direct address
      tgt = bdm_pkg::BDM_TGT_NONE; // RQ17
    end else if (bank <= `BDM_LAST_BANK) begin
      tgt = bdm_pkg::BDM_TGT_GPR; // RQ1
    end else if (bank == `BDM_LCD_BANK && ea <= `BDM_LCD_HI) begin
      tgt = bdm_pkg::BDM_TGT_LCD; // RQ2
    end else begin
      tgt = bdm_pkg::BDM_TGT_NONE; // RQ20
    end
    // Read the target; unknown places read zero
    case (tgt)
      bdm_pkg::BDM_TGT_GPR: mem_rd = gpr_r[gidx];
      bdm_pkg::BDM_TGT_LCD: mem_rd = lcd_r[lidx];
      bdm_pkg::BDM_TGT_SFR: begin
        case (ea)
          `BDM_PTR_A_ADDR:  mem_rd = pointer_a_r;
          `BDM_PTR_B_ADDR:  mem_rd = pointer_b_r;
          `BDM_BANK_ADDR:   mem_rd = {2'b00, bank_select_r};
          `BDM_ACC_ADDR:    mem_rd = working_register_r; // RQ8
          `BDM_STATUS_ADDR: mem_rd = {4'h0, flags_r};
          default:          mem_rd = periph_ok(ea) ? periph_r[pidx] : 8'h00; // RQ16
        endcase
      end
      default: mem_rd = 8'h00; // RQ4
    endcase
    // Immediate operands feed the unit in place of memory
    src = op_use_imm ? op_imm : mem_rd; // RQ8
  end

  // Shared arithmetic unit
  bdm_alu u_alu (
    .op       (op_code),
    .acc      (working_register_r),
    .src      (src),
    .flags_in (flags_r),
    .res      (res),
    .flg      (alu_flg),
    .upd      (alu_upd),
    .skip     (alu_skip)
  );

  // Destination choice: memory is only written from the unit result,
  // which means a copy between two locations always goes through the
  // working register first
  always_comb begin
    wr_acc = op_valid && (op_code == bdm_pkg::BDM_LD
             || (op_to_acc && op_code != bdm_pkg::BDM_ST && op_writes(op_code))); // RQ9
    wr_mem = op_valid && !op_use_imm && !wr_acc && op_writes(op_code)
             && op_code != bdm_pkg::BDM_LD; // RQ9
    wdata  = res;
  end

  // Next values of control state
  // Every register holds unless the
  // current op names it; defaults
  // first keep this free of latches
  // Priority inside one cycle:
  //  - load to working register
  //  - store into a special register
  //  - flags owned by the op
  // Owned flags beat a software
  // write to status, so a store to
  // status by an arithmetic op
  // keeps the computed flags
  // The done pulse is one cycle wide
  // and the skip pulse rides on it;
  // the core must act on the skip in
  // that same cycle, it is not held
  // Read data holds between ops so
  // a slow core can still pick it up
  always_comb begin
    op_done_nxt = op_valid;
    skip_nxt    = op_valid && alu_skip; // RQ13
    rd_data_nxt = op_valid ? res : rd_data_r;
    acc_nxt     = working_register_r;
    flags_nxt   = flags_r;
    bank_nxt    = bank_select_r;
    ptr_a_nxt   = pointer_a_r;
    ptr_b_nxt   = pointer_b_r;
    if (wr_acc) begin
      acc_nxt = res; // RQ8
    end
    // Special registers written through the memory path
    if (wr_mem && tgt == bdm_pkg::BDM_TGT_SFR) begin
      case (ea)
        `BDM_PTR_A_ADDR:  ptr_a_nxt = wdata; // RQ7
        `BDM_PTR_B_ADDR:  ptr_b_nxt = wdata; // RQ7
        `BDM_BANK_ADDR:   bank_nxt  = wdata[5:0]; // RQ7
        `BDM_ACC_ADDR:    acc_nxt   = wdata; // RQ8
        `BDM_STATUS_ADDR: flags_nxt = wdata[3:0];
        default:          acc_nxt   = acc_nxt;
      endcase
    end
    // Flags the operation owns win over a software write in the same cycle
    if (op_valid) begin
      flags_nxt = (flags_nxt & ~alu_upd) | (alu_flg & alu_upd); // RQ14
    end
  end

  // Register the control state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_done_r          <= 1'b0;
      skip_r             <= 1'b0;
      rd_data_r          <= `BDM_RST_BYTE;
      working_register_r <= `BDM_RST_BYTE;
      flags_r            <= `BDM_RST_FLAGS;
      bank_select_r      <= `BDM_RST_BANK; // RQ19
      pointer_a_r        <= `BDM_RST_BYTE;
      pointer_b_r        <= `BDM_RST_BYTE;
    end else begin
      op_done_r          <= op_done_nxt;
      skip_r             <= skip_nxt;
      rd_data_r          <= rd_data_nxt;
      working_register_r <= acc_nxt;
      flags_r            <= flags_nxt;
      bank_select_r      <= bank_nxt;
      pointer_a_r        <= ptr_a_nxt;
      pointer_b_r        <= ptr_b_nxt;
    end
  end

  // Write enables for the arrays
  // Enables are derived from the
  // already resolved target, so a
  // dropped write simply never
  // raises any enable here
  // Control bytes outside the mask
  // are absent and ignore writes
  always_comb begin
    gpr_we_nxt    = wr_mem && (tgt == bdm_pkg::BDM_TGT_GPR); // RQ1
    lcd_we_nxt    = wr_mem && (tgt == bdm_pkg::BDM_TGT_LCD); // RQ2
    periph_we_nxt = wr_mem && (tgt == bdm_pkg::BDM_TGT_SFR) && periph_ok(ea); // RQ15
  end

  // General and display memory; no reset keeps this cheap
  always_ff @(posedge clk) begin
    if (gpr_we_nxt) begin
      gpr_r[gidx] <= wdata;
    end
    if (lcd_we_nxt) begin
      lcd_r[lidx] <= wdata;
    end
  end

  // Control registers reset to zero so peripherals start idle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `BDM_PERIPH_WORDS; i++) begin
        periph_r[i] <= `BDM_RST_BYTE;
      end
    end else if (periph_we_nxt) begin
      periph_r[pidx] <= wdata;
    end
  end
endmodule : bdm_top
`default_nettype wire

// file: test/bdm_checker_asserts.sv
// Purpose: Port-level checks of the data memory block
// Assumes: One clock, active-low async reset
// Notes:   Bound onto bdm_top below
`timescale 1ns/100ps
`default_nettype none
module bdm_checker (
  input wire logic             clk,
  input wire logic             rst_b,
  input wire logic             op_valid,
  input wire bdm_pkg::bdm_op_t op_code,
  input wire logic [7:0]       op_addr,
  input wire logic [7:0]       op_imm,
  input wire logic             op_use_imm,
  input wire logic             op_to_acc,
  input wire logic             op_done_r,
  input wire logic             skip_r,
  input wire logic [7:0]       rd_data_r,
  input wire logic [7:0]       working_register_r,
  input wire logic [3:0]       flags_r,
  input wire logic [5:0]       bank_select_r,
  input wire logic [7:0]       tone_gen_control_r
);
  // Single domain, so clock and guard are shared
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Immediate operand aimed at the working register
  wire ld_imm = op_valid && op_use_imm && op_to_acc;
  // Plain store of the working register, no immediate
  wire st_mem = op_valid && op_code == bdm_pkg::BDM_ST && !op_use_imm;
  AST_DONE_FOLLOWS:
    assert property (op_done_r == $past(op_valid)) else $error("done does not follow request");
  AST_SKIP_WITH_DONE:
    assert property (skip_r |-> op_done_r) else $error("skip outside done");
  AST_LOAD_IMM:
    assert property (ld_imm && op_code == bdm_pkg::BDM_LD |=> working_register_r == $past(op_imm))
    else $error("immediate not loaded");
  AST_ADD_CARRY:
    assert property (ld_imm && op_code == bdm_pkg::BDM_ADD |=> {flags_r[0], working_register_r}
      == {1'b0, $past(working_register_r)} + {1'b0, $past(op_imm)}) else $error("bad sum");
  AST_AND_IMM:
    assert property (ld_imm && op_code == bdm_pkg::BDM_AND |=>
      working_register_r == ($past(working_register_r) & $past(op_imm))) else $error("bad and");
  AST_ZERO_FLAG:
    assert property (op_valid && op_code inside {bdm_pkg::BDM_XOR, bdm_pkg::BDM_INC} |=>
      flags_r[2] == (rd_data_r == 8'h00)) else $error("zero flag wrong");
  AST_BANK_STORE:
    assert property (st_mem && op_addr == 8'h04 |=> bank_select_r == $past(working_register_r[5:0]))
    else $error("bank select not stored");
  AST_TONE_STORE:
    assert property (st_mem && op_addr == 8'h20 |=> tone_gen_control_r == $past(working_register_r))
    else $error("control byte not stored");
  AST_IDLE_HOLDS:
    assert property (!op_valid |=> $stable(bank_select_r) && $stable(working_register_r)
      && $stable(flags_r)) else $error("state moved while idle");
  AST_SZ_DECIDES:
    assert property (op_valid && op_code == bdm_pkg::BDM_SZ |=> skip_r == (rd_data_r == 8'h00))
    else $error("skip decision wrong");
  // Main scenarios reached
  cover property (op_valid && op_code == bdm_pkg::BDM_SIZ ##1 skip_r);
  cover property (op_valid && op_addr == 8'h02 ##1 op_done_r);
  cover property (ld_imm && op_code == bdm_pkg::BDM_ADD ##1 flags_r[0]);
endmodule : bdm_checker
bind bdm_top bdm_checker u_bdm_checker (.clk(clk), .rst_b(rst_b), .op_valid(op_valid),
  .op_code(op_code), .op_addr(op_addr), .op_imm(op_imm), .op_use_imm(op_use_imm),
  .op_to_acc(op_to_acc), .op_done_r(op_done_r), .skip_r(skip_r), .rd_data_r(rd_data_r),
  .working_register_r(working_register_r), .flags_r(flags_r),
  .bank_select_r(bank_select_r), .tone_gen_control_r(tone_gen_control_r));
`default_nettype wire

// file: test/bdm_core_model.sv
// Purpose: Core-side issuer of one operation at a time
// Assumes: Requests launched just after a rising edge
// Notes:   slow adds idle cycles before each request
`timescale 1ns/100ps
`default_nettype none
module bdm_core_model (
  input  wire logic      clk,
  output logic           op_valid,
  output bdm_pkg::bdm_op_t op_code,
  output logic [7:0]     op_addr,
  output logic [7:0]     op_imm,
  output logic           op_use_imm,
  output logic           op_to_acc
);
  int slow = 0; // Idle cycles before a request
  // Quiet bus from time zero
  initial begin
    op_valid = 1'b0;
    op_code = bdm_pkg::BDM_NOP;
    op_addr = 8'h00;
    op_imm = 8'h00;
    op_use_imm = 1'b0;
    op_to_acc = 1'b0;
  end
  // Hold the request over exactly one taking edge
  task automatic issue(input bdm_pkg::bdm_op_t c, input logic [7:0] a, i, input logic u, t);
    repeat (slow) @(posedge clk);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_addr <= a;
    op_imm <= i;
    op_use_imm <= u;
    op_to_acc <= t;
    @(posedge clk);
    op_valid <= 1'b0;
    op_imm <= ~i; // Stale operand must not be reused
  endtask : issue
endmodule : bdm_core_model
`default_nettype wire

// file: test/tb_banked_data_memory_and_alu.sv
// Purpose: Directed tests of banked memory, pointers and arithmetic
// Assumes: Results settle just after the taking edge and are checked 1 ns later
// Notes:   Expected values worked out by hand from the flag rules
`timescale 1ns/100ps
`default_nettype none
module tb_banked_data_memory_and_alu;
  logic clk, rst_b, op_valid, op_use_imm, op_to_acc, op_done_r, skip_r;
  bdm_pkg::bdm_op_t op_code;
  logic [7:0] op_addr, op_imm, rd_data_r, working_register_r, pointer_a_r, pointer_b_r, tone_r;
  logic [3:0] flags_r, tf, tm;
  logic [5:0] bank_select_r;
  logic [4:0] tc;
  logic [7:0] ta, ti, tr;
  int error_cnt = 0;
  int samples_checked = 0;
  // Operation, acc, operand, result, flags, flag mask
  logic [36:0] tbl [17] = '{
    {5'h03, 8'h7f, 8'h01, 8'h80, 4'ha, 4'hf}, {5'h03, 8'hff, 8'h01, 8'h00, 4'h7, 4'hf},
    {5'h0e, 8'h00, 8'h00, 8'h01, 4'h0, 4'h1}, {5'h0f, 8'h00, 8'h01, 8'h00, 4'h1, 4'h1},
    {5'h04, 8'h10, 8'h01, 8'h12, 4'h0, 4'hf}, {5'h05, 8'h05, 8'h05, 8'h00, 4'h7, 4'hf},
    {5'h06, 8'h10, 8'h01, 8'h0f, 4'h1, 4'hf}, {5'h03, 8'h15, 8'h27, 8'h3c, 4'h0, 4'hf},
    {5'h07, 8'h3c, 8'h00, 8'h42, 4'h0, 4'h1}, {5'h08, 8'hf0, 8'h0f, 8'h00, 4'h4, 4'h4},
    {5'h09, 8'h00, 8'h00, 8'h00, 4'h4, 4'h4}, {5'h0a, 8'h5a, 8'h5a, 8'h00, 4'h4, 4'h4},
    {5'h0b, 8'h00, 8'ha5, 8'h5a, 4'h0, 4'h4}, {5'h0c, 8'h00, 8'h81, 8'h03, 4'h0, 4'h0},
    {5'h0d, 8'h00, 8'h81, 8'hc0, 4'h0, 4'h0}, {5'h10, 8'h00, 8'hff, 8'h00, 4'h4, 4'h4},
    {5'h11, 8'h00, 8'h01, 8'h00, 4'h4, 4'h4}};
  bdm_core_model u_bdm_core_model (.clk(clk), .op_valid(op_valid), .op_code(op_code),
    .op_addr(op_addr), .op_imm(op_imm), .op_use_imm(op_use_imm), .op_to_acc(op_to_acc));
  bdm_top u_bdm_top (.clk(clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
    .op_addr(op_addr), .op_imm(op_imm), .op_use_imm(op_use_imm), .op_to_acc(op_to_acc),
    .op_done_r(op_done_r), .skip_r(skip_r), .rd_data_r(rd_data_r),
    .working_register_r(working_register_r), .flags_r(flags_r), .bank_select_r(bank_select_r),
    .pointer_a_r(pointer_a_r), .pointer_b_r(pointer_b_r), .tone_gen_control_r(tone_r));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One operation, then its done pulse
  task automatic op(input logic [4:0] c, input logic [7:0] a, i, input logic u, t);
    u_bdm_core_model.issue(bdm_pkg::bdm_op_t'(c), a, i, u, t);
    #1;
    chk("done", {7'h00, op_done_r}, 8'h01);
  endtask : op
  task automatic setacc(input logic [7:0] v);
    op(5'h01, 8'h00, v, 1'b1, 1'b1);
  endtask : setacc
  // Memory moves always pass the working register
  task automatic wr(input logic [7:0] a, v);
    setacc(v);
    op(5'h02, a, 8'h00, 1'b0, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    op(5'h01, a, 8'h00, 1'b0, 1'b1);
    chk("read", rd_data_r, e);
  endtask : rd
  task automatic skp(input logic [4:0] c, input logic e);
    op(c, 8'h41, 8'h00, 1'b0, 1'b0);
    chk("skip", {7'h00, skip_r}, {7'h00, e});
  endtask : skp
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #100000;
    error_cnt++;
    $display("ERROR watchdog expired");
    give_verdict();
  end
  initial begin
    rst_b = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk("bank", {2'b00, bank_select_r}, 8'h00);
    chk("ptr", pointer_b_r, 8'h00);
    chk("tone", tone_r, 8'h00);
    $display("test reset done");
    wr(8'h40, 8'h5a); rd(8'h40, 8'h5a);
    wr(8'h20, 8'ha5); chk("tone", tone_r, 8'ha5);
    wr(8'h23, 8'hff); rd(8'h23, 8'h00);
    setacc(8'h3c); rd(8'h05, 8'h3c);
    wr(8'h60, 8'h11);
    $display("test map done");
    wr(8'h01, 8'h40); rd(8'h00, 8'h5a);
    wr(8'h03, 8'h60); wr(8'h04, 8'h03); wr(8'h02, 8'h77); rd(8'h02, 8'h77);
    u_bdm_core_model.slow = 2;
    rd(8'h60, 8'h00);
    wr(8'h01, 8'h60); rd(8'h00, 8'h11);
    u_bdm_core_model.slow = 0;
    wr(8'h03, 8'h20); rd(8'h02, 8'ha5);
    wr(8'h03, 8'h00); wr(8'h02, 8'h99); rd(8'h02, 8'h00);
    rd(8'h00, 8'h11);
    wr(8'h04, 8'h1b); wr(8'h03, 8'h9f); wr(8'h02, 8'h3c); rd(8'h02, 8'h3c);
    wr(8'h03, 8'ha0); wr(8'h02, 8'h3c); rd(8'h02, 8'h00);
    wr(8'h04, 8'h0f); wr(8'h03, 8'h40); wr(8'h02, 8'h42); rd(8'h02, 8'h00);
    wr(8'h04, 8'hff); chk("bank", {2'b00, bank_select_r}, 8'h3f);
    wr(8'h04, 8'h00); rd(8'h60, 8'h11);
    $display("test indirect done");
    // Flags carry across rows, so order matters
    for (int k = 0; k < 17; k++) begin
      {tc, ta, ti, tr, tf, tm} = tbl[k];
      setacc(ta);
      op(tc, 8'h00, ti, 1'b1, 1'b1);
      chk("result", working_register_r, tr);
      chk("flags", {4'h0, flags_r & tm}, {4'h0, tf});
    end
    $display("test alu done");
    wr(8'h41, 8'h00); skp(5'h12, 1'b1); skp(5'h13, 1'b0);
    wr(8'h41, 8'hff); skp(5'h14, 1'b1); skp(5'h15, 1'b0);
    rd(8'h41, 8'hff);
    $display("test skip done");
    give_verdict();
  end
endmodule : tb_banked_data_memory_and_alu
`default_nettype wire
